// >>> rtl/trts_dev.sv
`timescale 1ns/1ps
// Operation
// - power-down stops coding, serial, recovery, express logic
// - reference clock buffers stay powered during power-down
// - tx logic reset holds tx coding; two cycles
// - rx analog reset resets receiver analog; two cycles
// - rx logic reset holds rx coding; two cycles
// - reconfig clock drives reconfig and offset cancel
// - reconfig bus in from controller, status back
// - calibration clocked by calib clock, powerable down
// - fixed mode: done on cycle or error, sticky
// - prbs mode: done on full cycle, sticky
// - fixed mode: error sticky until rx reset or power-down
// - prbs error at least three cycles, clears
module trts_dev import trts_pkg::*; #(
  parameter int CYCLE_LEN = TRTS_CYCLE_LEN
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // receive data seen by the verifier, same clock
  input wire logic [TRTS_PAT_W-1:0] rx_data,
  input wire logic rx_valid,
  // user side status
  output logic refclk_buf_on,
  output logic pcs_powered,
  output logic tx_coding_run,
  output logic rx_analog_run,
  output logic rx_coding_run,
  output logic offset_cancel_run,
  output logic calib_run,
  output logic [TRTS_RCFG_W-1:0] rcfg_cfg,
  // link
  trts_if.dev lnk
);
  localparam int CW = $clog2(CYCLE_LEN + 1);
  typedef struct packed {
    logic [1:0] pd_s;
    logic [1:0] cpd_s;
    logic [1:0] pipe_s;
    logic [1:0][1:0] mode_s;
    logic [2:0][1:0] rst_s;
    logic [TRTS_RCFG_W-1:0] rc_s1;
    logic [TRTS_RCFG_W-1:0] rc_s2;
    logic [TRTS_RCFG_W-1:0] rc_out;
    logic [TRTS_PAT_W-1:0] lfsr;
    logic [CW-1:0] pos;
    logic seq_err;
    logic done;
    logic err;
    logic [TRTS_CNT_W-1:0] err_cnt;
    logic pcs_on;
    logic tx_run;
    logic rxa_run;
    logic rx_run;
    logic ofs_run;
    logic cal_run;
    logic ref_on;
  } trts_dev_t;
  trts_dev_t st_reg, st_next;
  logic pd, cpd, pipe, tx_rst, rxa_rst, rx_rst, hit_err, last;
  logic [1:0] mode;
  logic [TRTS_PAT_W-1:0] expect_w;
  always_comb begin
    st_next = st_reg;
    // only the second stage of each synchroniser is read
    st_next.pd_s = {st_reg.pd_s[0], lnk.block_power_down};
    st_next.cpd_s = {st_reg.cpd_s[0], lnk.calib_power_down};
    st_next.pipe_s = {st_reg.pipe_s[0], lnk.pipe_mode};
    st_next.mode_s = {st_reg.mode_s[0], lnk.test_mode};
    st_next.rst_s[0] = {st_reg.rst_s[0][0], lnk.tx_logic_reset};
    st_next.rst_s[1] = {st_reg.rst_s[1][0], lnk.rx_analog_reset};
    st_next.rst_s[2] = {st_reg.rst_s[2][0], lnk.rx_logic_reset};
    st_next.rc_s1 = lnk.reconfig_to_transceiver;
    st_next.rc_s2 = st_reg.rc_s1;
    pd = st_reg.pd_s[1];
    cpd = st_reg.cpd_s[1];
    pipe = st_reg.pipe_s[1];
    mode = st_reg.mode_s[1];
    tx_rst = st_reg.rst_s[0][1];
    rxa_rst = st_reg.rst_s[1][1];
    rx_rst = st_reg.rst_s[2][1];
    st_next.ref_on = 1'b1;
    st_next.pcs_on = !pd;
    st_next.tx_run = !pd && !tx_rst;
    st_next.rxa_run = !pd && !rxa_rst;
    st_next.rx_run = !pd && !rx_rst;
    // pipe mode offset cancel runs without the reconfig clock
    st_next.ofs_run = !pd && (pipe || !rxa_rst);
    st_next.cal_run = !cpd;
    if (!pd) begin
      st_next.rc_out = st_reg.rc_s2;
    end
    expect_w = (mode == TRTS_MODE_FIXED) ? TRTS_FIXED_PAT : st_reg.lfsr;
    hit_err = rx_valid && (rx_data != expect_w);
    last = rx_valid && (st_reg.pos == CW'(CYCLE_LEN - 1));
    if (st_reg.err_cnt != '0) begin
      st_next.err_cnt = st_reg.err_cnt - 1'b1;
    end
    if (pd || rx_rst || mode == TRTS_MODE_OFF) begin
      // sticky flags drop only on power-down or receive logic reset
      st_next.lfsr = TRTS_PRBS_SEED;
      st_next.pos = '0;
      st_next.seq_err = 1'b0;
      st_next.err_cnt = '0;
      if (pd || rx_rst) begin
        st_next.done = 1'b0;
        st_next.err = 1'b0;
      end
    end else if (rx_valid) begin
      st_next.lfsr = {st_reg.lfsr[TRTS_PAT_W-2:0], ^(st_reg.lfsr & TRTS_PRBS_TAPS)};
      st_next.pos = last ? '0 : st_reg.pos + 1'b1;
      if (mode == TRTS_MODE_FIXED) begin
        if (last || hit_err) begin
          st_next.done = 1'b1;
        end
        if (hit_err) begin
          st_next.err = 1'b1;
        end
      end else begin
        if (last) begin
          st_next.done = 1'b1;
        end
        st_next.seq_err = last ? 1'b0 : (st_reg.seq_err || hit_err);
        if (hit_err) begin
          st_next.err = 1'b1;
          st_next.err_cnt = TRTS_CNT_W'(TRTS_ERR_MIN_CYC - 1);
        end else if (last && !st_reg.seq_err && st_reg.err_cnt == '0) begin
          st_next.err = 1'b0;
        end
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lnk.test_done = st_reg.done;
  assign lnk.test_error = st_reg.err;
  assign lnk.reconfig_from_transceiver = st_reg.rc_out;
  assign refclk_buf_on = st_reg.ref_on;
  assign pcs_powered = st_reg.pcs_on;
  assign tx_coding_run = st_reg.tx_run;
  assign rx_analog_run = st_reg.rxa_run;
  assign rx_coding_run = st_reg.rx_run;
  assign offset_cancel_run = st_reg.ofs_run;
  assign calib_run = st_reg.cal_run;
  assign rcfg_cfg = st_reg.rc_s2;
endmodule : trts_dev

// >>> rtl/trts_pkg.sv
package trts_pkg;
  // test mode select
  localparam logic [1:0] TRTS_MODE_OFF = 2'h0;
  localparam logic [1:0] TRTS_MODE_FIXED = 2'h1;
  localparam logic [1:0] TRTS_MODE_PRBS = 2'h2;
  // least reset pulse width in parallel clock cycles
  localparam int TRTS_RST_MIN_CYC = 2;
  // least error pulse in prbs mode, recovered clock cycles
  localparam int TRTS_ERR_MIN_CYC = 3;
  localparam int TRTS_CNT_W = 4;
  localparam int TRTS_PAT_W = 8;
  localparam logic [TRTS_PAT_W-1:0] TRTS_FIXED_PAT = 8'ha5;
  localparam logic [TRTS_PAT_W-1:0] TRTS_PRBS_SEED = 8'hff;
  // prbs7-like taps on an 8-bit lfsr
  localparam logic [TRTS_PAT_W-1:0] TRTS_PRBS_TAPS = 8'hb8;
  localparam int TRTS_CYCLE_LEN = 16;
  localparam int TRTS_RCFG_W = 4;
endpackage : trts_pkg

// >>> rtl/trts_if.sv
`timescale 1ns/1ps
interface trts_if import trts_pkg::*; ();
  logic block_power_down;
  logic tx_logic_reset;
  logic rx_analog_reset;
  logic rx_logic_reset;
  logic pipe_mode;
  logic [1:0] test_mode;
  logic [TRTS_RCFG_W-1:0] reconfig_to_transceiver;
  logic [TRTS_RCFG_W-1:0] reconfig_from_transceiver;
  logic calib_power_down;
  logic test_done;
  logic test_error;
  modport dev (
    input block_power_down, tx_logic_reset, rx_analog_reset, rx_logic_reset,
    input pipe_mode, test_mode, reconfig_to_transceiver, calib_power_down,
    output reconfig_from_transceiver, test_done, test_error
  );
  modport host (
    output block_power_down, tx_logic_reset, rx_analog_reset, rx_logic_reset,
    output pipe_mode, test_mode, reconfig_to_transceiver, calib_power_down,
    input reconfig_from_transceiver, test_done, test_error
  );
endinterface : trts_if

// >>> rtl/trts_host.sv
`timescale 1ns/1ps
// fabric side: stretches reset requests to the least width, drives controls
module trts_host import trts_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // user side
  input wire logic pwr_down_req,
  input wire logic tx_rst_req,
  input wire logic rx_ana_rst_req,
  input wire logic rx_log_rst_req,
  input wire logic pipe_mode_sel,
  input wire logic [1:0] test_mode_sel,
  input wire logic cal_pwr_down_req,
  input wire logic [TRTS_RCFG_W-1:0] rcfg_wr,
  output logic [TRTS_RCFG_W-1:0] rcfg_rd,
  output logic done_seen,
  output logic err_seen,
  // link
  trts_if.host lnk
);
  typedef struct packed {
    logic pd;
    logic cpd;
    logic pipe;
    logic [1:0] mode;
    logic [TRTS_RCFG_W-1:0] rcfg_o;
    logic [2:0][TRTS_CNT_W-1:0] cnt;
    logic [2:0] rst;
    logic [1:0] done_s;
    logic [1:0] err_s;
    logic [TRTS_RCFG_W-1:0] rcfg_s1;
    logic [TRTS_RCFG_W-1:0] rcfg_s2;
  } trts_host_t;
  trts_host_t st_reg, st_next;
  logic [2:0] req;
  assign req = {rx_log_rst_req, rx_ana_rst_req, tx_rst_req};
  always_comb begin
    st_next = st_reg;
    st_next.pd = pwr_down_req;
    st_next.cpd = cal_pwr_down_req;
    st_next.pipe = pipe_mode_sel;
    st_next.mode = test_mode_sel;
    st_next.rcfg_o = rcfg_wr;
    st_next.done_s = {st_reg.done_s[0], lnk.test_done};
    st_next.err_s = {st_reg.err_s[0], lnk.test_error};
    st_next.rcfg_s1 = lnk.reconfig_from_transceiver;
    st_next.rcfg_s2 = st_reg.rcfg_s1;
    for (int i = 0; i < 3; i++) begin
      // every assertion held at least the least width
      if (req[i]) begin
        st_next.rst[i] = 1'b1;
        st_next.cnt[i] = TRTS_CNT_W'(TRTS_RST_MIN_CYC - 1);
      end else if (st_reg.cnt[i] != '0) begin
        st_next.cnt[i] = st_reg.cnt[i] - 1'b1;
      end else begin
        st_next.rst[i] = 1'b0;
      end
    end
  end
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign lnk.block_power_down = st_reg.pd;
  assign lnk.calib_power_down = st_reg.cpd;
  assign lnk.pipe_mode = st_reg.pipe;
  assign lnk.test_mode = st_reg.mode;
  assign lnk.reconfig_to_transceiver = st_reg.rcfg_o;
  assign lnk.tx_logic_reset = st_reg.rst[0];
  assign lnk.rx_analog_reset = st_reg.rst[1];
  assign lnk.rx_logic_reset = st_reg.rst[2];
  assign rcfg_rd = st_reg.rcfg_s2;
  assign done_seen = st_reg.done_s[1];
  assign err_seen = st_reg.err_s[1];
endmodule : trts_host

// >>> verification/trts_checker.sv
`timescale 1ns/1ps
module trts_checker import trts_pkg::*; (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // link
  input wire logic block_power_down,
  input wire logic tx_logic_reset,
  input wire logic rx_analog_reset,
  input wire logic rx_logic_reset,
  input wire logic [1:0] test_mode,
  input wire logic [TRTS_RCFG_W-1:0] reconfig_to_transceiver,
  input wire logic [TRTS_RCFG_W-1:0] reconfig_from_transceiver,
  input wire logic test_done,
  input wire logic test_error
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!resetn);
  // deep enough to span the reset synchroniser in the dev
  logic [4:0] clr_reg;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) clr_reg <= 5'h1f;
    else clr_reg <= {clr_reg[3:0], rx_logic_reset | block_power_down};
  end
  property p_tx_w; $rose(tx_logic_reset) |=> tx_logic_reset; endproperty
  a_tx_w: assert property (p_tx_w) else $error("tx reset too short");
  property p_ana_w; $rose(rx_analog_reset) |=> rx_analog_reset; endproperty
  a_ana_w: assert property (p_ana_w) else $error("analog reset too short");
  property p_rx_w; $rose(rx_logic_reset) |=> rx_logic_reset; endproperty
  a_rx_w: assert property (p_rx_w) else $error("rx reset too short");
  property p_done_hold; $fell(test_done) |-> |clr_reg; endproperty
  a_done_hold: assert property (p_done_hold) else $error("done dropped alone");
  property p_err_fix; $fell(test_error) && test_mode == TRTS_MODE_FIXED |-> |clr_reg; endproperty
  a_err_fix: assert property (p_err_fix) else $error("fixed error dropped");
  property p_err_min; $rose(test_error) && test_mode == TRTS_MODE_PRBS |=> test_error[*2];
  endproperty
  a_err_min: assert property (p_err_min) else $error("prbs error too short");
  property p_done_mode; $rose(test_done) |-> test_mode != TRTS_MODE_OFF; endproperty
  a_done_mode: assert property (p_done_mode) else $error("done with test off");
  property p_rcfg;
    (!block_power_down)[*5] |-> reconfig_from_transceiver == $past(reconfig_to_transceiver, 3);
  endproperty
  a_rcfg: assert property (p_rcfg) else $error("reconfig status wrong");
  c_prbs_err: cover property ($rose(test_error) && test_mode == TRTS_MODE_PRBS);
  c_prbs_clr: cover property ($fell(test_error) && test_mode == TRTS_MODE_PRBS);
  c_fix_done: cover property ($rose(test_done) && test_mode == TRTS_MODE_FIXED);
endmodule : trts_checker

// >>> verification/tb_transceiver_reset_test_status.sv
`timescale 1ns/1ps
module tb_transceiver_reset_test_status import trts_pkg::*;;
  logic sys_clk = 1'h0, resetn = 1'h0, pwr_down_req = 1'h0, tx_rst_req = 1'h0;
  logic rx_ana_rst_req = 1'h0, rx_log_rst_req = 1'h0, cal_pwr_down_req = 1'h0;
  logic pipe_mode_sel = 1'h0, rx_valid = 1'h0, done_seen, err_seen, refclk_buf_on, pcs_powered;
  logic tx_coding_run, rx_analog_run, rx_coding_run, offset_cancel_run, calib_run;
  logic [1:0] test_mode_sel = 2'h0;
  logic [TRTS_RCFG_W-1:0] rcfg_wr = 4'h0, rcfg_rd, rcfg_cfg;
  logic [7:0] rx_data = 8'h0, lfsr;
  int bad_count = 0, compares = 0, cyc = 0;
  trts_if lnk ();
  always #2 sys_clk = ~sys_clk;
  trts_host trts_host_inst (.sys_clk, .resetn, .pwr_down_req, .tx_rst_req, .rx_ana_rst_req,
    .rx_log_rst_req, .pipe_mode_sel, .test_mode_sel, .cal_pwr_down_req, .rcfg_wr, .rcfg_rd,
    .done_seen, .err_seen, .lnk(lnk.host));
  trts_dev #(.CYCLE_LEN(16)) trts_dev_inst (.sys_clk, .resetn, .rx_data, .rx_valid,
    .refclk_buf_on, .pcs_powered, .tx_coding_run, .rx_analog_run, .rx_coding_run,
    .offset_cancel_run, .calib_run, .rcfg_cfg, .lnk(lnk.dev));
  trts_checker trts_checker_inst (.sys_clk, .resetn, .block_power_down(lnk.block_power_down),
    .tx_logic_reset(lnk.tx_logic_reset), .rx_analog_reset(lnk.rx_analog_reset),
    .rx_logic_reset(lnk.rx_logic_reset), .test_mode(lnk.test_mode),
    .reconfig_to_transceiver(lnk.reconfig_to_transceiver),
    .reconfig_from_transceiver(lnk.reconfig_from_transceiver),
    .test_done(lnk.test_done), .test_error(lnk.test_error));
  task tick(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  task chk(string name, logic [3:0] exp, logic [3:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  task close_out;
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : close_out
  // one-cycle request; the host stretches it on the link
  task rx_clear;
    rx_log_rst_req = 1'h1;
    tick(1);
    rx_log_rst_req = 1'h0;
    tick(8);
  endtask : rx_clear
  // valid stays up so back-to-back words need no gap
  task send(logic [7:0] d);
    rx_data = d;
    rx_valid = 1'h1;
    tick(1);
  endtask : send
  task t_ctrl;
    rcfg_wr = 4'ha;
    tx_rst_req = 1'h1;
    rx_ana_rst_req = 1'h1;
    cal_pwr_down_req = 1'h1;
    tick(8);
    chk("rcfg_cfg", 4'ha, rcfg_cfg);
    chk("rcfg_rd", 4'ha, rcfg_rd);
    chk("tx_run", 4'h0, tx_coding_run);
    chk("ana_run", 4'h0, rx_analog_run);
    chk("offset_rst", 4'h0, offset_cancel_run);
    chk("rx_run_on", 4'h1, rx_coding_run);
    chk("calib", 4'h0, calib_run);
    {tx_rst_req, rx_ana_rst_req, cal_pwr_down_req, pwr_down_req} = 4'h1;
    tick(8);
    chk("pcs_off", 4'h0, pcs_powered);
    chk("refclk", 4'h1, refclk_buf_on);
    chk("rx_run_pd", 4'h0, rx_coding_run);
    chk("ana_run_pd", 4'h0, rx_analog_run);
    pwr_down_req = 1'h0;
    tick(8);
    chk("pcs_on", 4'h1, pcs_powered);
    chk("tx_back", 4'h1, tx_coding_run);
    chk("calib_on", 4'h1, calib_run);
    chk("offset", 4'h1, offset_cancel_run);
    chk("ana_back", 4'h1, rx_analog_run);
    chk("rx_back", 4'h1, rx_coding_run);
  endtask : t_ctrl
  task t_fixed;
    test_mode_sel = TRTS_MODE_FIXED;
    rx_clear();
    for (int i = 0; i < 15; i++) send(TRTS_FIXED_PAT);
    rx_valid = 1'h0;
    tick(6);
    chk("done_early", 4'h0, done_seen);
    send(TRTS_FIXED_PAT);
    rx_valid = 1'h0;
    tick(6);
    chk("done_cyc", 4'h1, done_seen);
    chk("err_clean", 4'h0, err_seen);
    rx_clear();
    chk("done_clr", 4'h0, done_seen);
    send(8'h5a);
    rx_valid = 1'h0;
    tick(26);
    chk("done_err", 4'h1, done_seen);
    chk("err_held", 4'h1, err_seen);
    rx_clear();
    chk("err_clr", 4'h0, err_seen);
  endtask : t_fixed
  task t_prbs;
    test_mode_sel = TRTS_MODE_PRBS;
    rx_clear();
    lfsr = TRTS_PRBS_SEED;
    for (int i = 0; i < 48; i++) begin
      send(i == 2 ? ~lfsr : lfsr);
      lfsr = {lfsr[6:0], ^(lfsr & TRTS_PRBS_TAPS)};
      if (i == 8) chk("err_prbs", 4'h1, err_seen);
    end
    rx_valid = 1'h0;
    tick(6);
    chk("err_drop", 4'h0, err_seen);
    chk("done_prbs", 4'h1, done_seen);
  endtask : t_prbs
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    tick(12);
    resetn = 1'h1;
    tick(2);
    t_ctrl();
    t_fixed();
    t_prbs();
    close_out();
  end
endmodule : tb_transceiver_reset_test_status
